// ---- core/phy_event_defs.svh ----
// Offsets, field positions, reset values and timing counts of the PHY
// event and status register group.
// Assumes a 20 MHz system clock and a plain register port.
`ifndef PHY_EVENT_DEFS_SVH
`define PHY_EVENT_DEFS_SVH

// Register indices as printed.
`define EVENT_SOURCE_FLAGS_OFS       5'h1D
`define EVENT_ENABLE_MASK_OFS        5'h1E
`define NEGOTIATION_SPEED_STATUS_OFS 5'h1F
// Own additions: interrupt status and mask for the block's own events.
`define IRQ_STATUS_OFS               5'h1A
`define IRQ_MASK_OFS                 5'h1B

// Event flag bit positions.
`define LINE_ENERGY_BIT      7
`define NEG_COMPLETE_BIT     6
`define REMOTE_FAULT_BIT     5
`define LINK_LOST_BIT        4
`define PARTNER_ACK_BIT      3
`define PAR_DET_FAULT_BIT    2
`define PAGE_RECEIVED_BIT    1

// Status register fields.
`define AUTODONE_BIT         12
`define FILLER_LSB           5
`define FILLER_MSB           11
`define FILLER_RESET         7'h02
`define SPEED_LSB            2
`define SPEED_MSB            4

// Resolved speed and duplex codes.
`define SPD_10_HALF          3'h1
`define SPD_10_FULL          3'h5
`define SPD_100_HALF         3'h2
`define SPD_100_FULL         3'h6

// Energy timeout.
`define ENERGY_TIMEOUT_MS    256
`define CLK_HZ               20000000

`endif

// ---- core/phy_event_pkg.sv ----
// Types shared by the PHY event and status register group.
// Assumes the constants header is included by its users.
package phy_event_pkg;

  // Raw event indications from the PHY core, one-cycle or level.
  typedef struct packed {
    logic page_received;
    logic par_det_fault;
    logic partner_ack;
    logic link_up;
    logic remote_fault;
    logic neg_complete;
    logic energy_seen;
  } phy_events_t;

  // Register port request.
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // State of the energy watchdog.
  typedef enum logic [0:0] {
    ENERGY_ON,
    ENERGY_OFF
  } energy_state_t;

endpackage

// ---- core/energy_watch.sv ----
// Energy watchdog: holds line energy present until no energy for a timeout.
// Assumes energy_seen is synchronous to clk_sys.
`include "phy_event_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module energy_watch
  import phy_event_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES =
    `ENERGY_TIMEOUT_MS * (`CLK_HZ / 1000)
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic energy_seen,
  output var  logic present
);

  typedef struct packed {
    energy_state_t st;
    logic [31:0]   cnt;
    logic          present;
  } ew_state_t;

  ew_state_t s_q;
  ew_state_t s_d;

  // Count quiet cycles; energy restarts the count and restores presence.
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      ENERGY_ON: begin
        if (energy_seen) begin
          s_d.cnt = 32'h0;
        end else if (s_q.cnt >= TIMEOUT_CYCLES - 1) begin
          s_d.st = ENERGY_OFF;
          s_d.present = 1'b0;
          s_d.cnt = 32'h0;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      ENERGY_OFF: begin
        if (energy_seen) begin
          s_d.st = ENERGY_ON;
          s_d.present = 1'b1;
        end
      end
      default: s_d = s_q;
    endcase
  end

  // Hardware reset brings presence back to one.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '{st: ENERGY_ON, cnt: 32'h0, present: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign present = s_q.present;

endmodule
`default_nettype wire

// ---- core/phy_event_flags.sv ----
// PHY event flag, event mask and negotiation status registers.
// Assumes event inputs synchronous to clk_sys and a one-cycle register port.
//
// Operation
// - Bit 7 latches when line energy becomes present.
// - Bit 6 latches when auto-negotiation completes.
// - Bit 5 latches when the partner reports a remote fault.
// - Bit 4 latches when the link goes down.
// - Bit 3 latches when the partner acknowledge arrives.
// - Bit 2 latches on a parallel detection fault.
// - Bit 1 latches when a negotiation page is received.
// - Flag bits 15 to 8 and 0 read zero after reset.
// - After reset the link-lost flag reflects the present link state.
// - Mask bits 7 to 0 are writable, reset zero, one enables.
// - Mask bits 15 to 8 read zero; master writes them zero.
// - Status bit 12 shows negotiation done, reset zero.
// - Status bits 4 to 2 give resolved speed and duplex code.
// - Status bits 11 to 5 writable, reset to 0000010b.
// - Energy present drops after 256 ms quiet, returns when energy is seen again or on reset.
//
// Strobed register access was chosen for this implementation.
`include "phy_event_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module phy_event_flags
  import phy_event_pkg::*;
#(
  parameter int unsigned ENERGY_TIMEOUT_CYCLES =
    `ENERGY_TIMEOUT_MS * (`CLK_HZ / 1000)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire phy_events_t ev,
  input  wire logic        autodone,
  input  wire logic [2:0]  resolved_speed_duplex,
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             phy_irq,
  output logic             blk_irq,
  output logic             line_energy_present
);

  // Whole state of the register group.
  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [6:0]  filler;
    logic        autodone;
    logic [2:0]  speed;
    logic        energy_d1;
    logic        link_d1;
    logic        neg_d1;
    logic        first;
    logic [15:0] rdata;
    logic        phy_irq;
    logic [1:0]  irq_sts;
    logic [1:0]  irq_msk;
    logic        blk_irq;
  } regs_t;

  regs_t s_q;
  regs_t s_d;

  logic energy_now;
  logic [7:0] hit;
  logic [7:0] level;
  logic [15:0] rd_val;

  energy_watch #(
    .TIMEOUT_CYCLES (ENERGY_TIMEOUT_CYCLES)
  ) u_energy (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .energy_seen (ev.energy_seen),
    .present     (energy_now)
  );

  // Event detection: edges and levels that set each flag.
  always_comb begin
    hit = 8'h00;
    level = 8'h00;
    hit[`LINE_ENERGY_BIT] = energy_now & ~s_q.energy_d1;
    hit[`NEG_COMPLETE_BIT] = ev.neg_complete & ~s_q.neg_d1;
    hit[`REMOTE_FAULT_BIT] = ev.remote_fault;
    hit[`LINK_LOST_BIT] = ~ev.link_up & s_q.link_d1;
    hit[`PARTNER_ACK_BIT] = ev.partner_ack;
    hit[`PAR_DET_FAULT_BIT] = ev.par_det_fault;
    hit[`PAGE_RECEIVED_BIT] = ev.page_received;
    // Conditions still standing keep their flag through a read.
    level[`REMOTE_FAULT_BIT] = ev.remote_fault;
    level[`LINK_LOST_BIT] = ~ev.link_up;
    level[`PAR_DET_FAULT_BIT] = ev.par_det_fault;
  end

  // Read multiplexer; unmapped indices read zero.
  always_comb begin
    case (addr)
      `EVENT_SOURCE_FLAGS_OFS: rd_val = {8'h00, s_q.flags};
      `EVENT_ENABLE_MASK_OFS: rd_val = {8'h00, s_q.mask};
      `NEGOTIATION_SPEED_STATUS_OFS: begin
        rd_val = 16'h0000;
        rd_val[`AUTODONE_BIT] = s_q.autodone;
        rd_val[`FILLER_MSB:`FILLER_LSB] = s_q.filler;
        rd_val[`SPEED_MSB:`SPEED_LSB] = s_q.speed;
      end
      `IRQ_STATUS_OFS: rd_val = {14'h0000, s_q.irq_sts};
      `IRQ_MASK_OFS: rd_val = {14'h0000, s_q.irq_msk};
      default: rd_val = 16'h0000;
    endcase
  end

  // Next state of every register.
  always_comb begin
    logic [7:0] nf;
    logic [1:0] ev2;
    s_d = s_q;
    nf = s_q.flags;
    ev2 = 2'b00;
    s_d.energy_d1 = energy_now;
    s_d.link_d1 = ev.link_up;
    s_d.neg_d1 = ev.neg_complete;
    s_d.autodone = autodone;
    s_d.speed = resolved_speed_duplex;
    s_d.first = 1'b0;
    s_d.rdata = rd ? rd_val : 16'h0000;
    // A read clears the flags; live conditions and new hits win.
    if (rd && addr == `EVENT_SOURCE_FLAGS_OFS) begin
      nf = level;
    end
    nf = nf | hit;
    if (s_q.first) begin
      nf[`LINK_LOST_BIT] = ~ev.link_up;
    end
    nf[0] = 1'b0;
    s_d.flags = nf;
    if (wr && addr == `EVENT_ENABLE_MASK_OFS) begin
      s_d.mask = wdata[7:0];
    end
    if (wr && addr == `NEGOTIATION_SPEED_STATUS_OFS) begin
      s_d.filler = wdata[`FILLER_MSB:`FILLER_LSB];
    end
    if (wr && addr == `IRQ_MASK_OFS) begin
      s_d.irq_msk = wdata[1:0];
    end
    // Block events: any flag newly latched, and energy loss.
    ev2[0] = |(nf & ~s_q.flags);
    ev2[1] = s_q.energy_d1 & ~energy_now;
    if (wr && addr == `IRQ_STATUS_OFS) begin
      s_d.irq_sts = s_q.irq_sts & ~wdata[1:0];
    end
    s_d.irq_sts = s_d.irq_sts | ev2; // Set wins over a clear.
    s_d.phy_irq = |(nf & s_d.mask);
    s_d.blk_irq = |(s_d.irq_sts & s_d.irq_msk);
  end

  // Registers; the first cycle after reset samples the link.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.filler <= `FILLER_RESET;
      s_q.energy_d1 <= 1'b1;
      s_q.link_d1 <= 1'b0;
      s_q.first <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign phy_irq = s_q.phy_irq;
  assign blk_irq = s_q.blk_irq;
  assign line_energy_present = s_q.energy_d1;

endmodule
`default_nettype wire

// ---- tb/phy_core_model.sv ----
// Model of the PHY core's event, negotiation and speed indications.
// Assumes the bench calls blip just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module phy_core_model
  import phy_event_pkg::*;
(
  input  wire logic   clk_sys,
  output var phy_events_t ev,
  output var logic       autodone,
  output var logic [2:0] spd
);
  // Start with the link down so the first cycle after reset sees it lost.
  initial begin
    ev = 7'h01;
    autodone = 1'b0;
    spd = 3'h1;
  end
  // Flips one indication for one cycle: a pulse, an edge or a brief fault.
  task automatic blip(input int b);
    ev[b] <= ~ev[b];
    @(posedge clk_sys);
    ev[b] <= ~ev[b];
  endtask
endmodule
`default_nettype wire

// ---- tb/phy_event_flags_checker.sv ----
// Port-level checks of the PHY event, mask and status registers.
// Assumes one clock domain; bound to the design from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module phy_event_flags_checker
  import phy_event_pkg::*;
#(parameter int unsigned ENERGY_TIMEOUT_CYCLES = 20)
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire phy_events_t ev,
  input wire logic        autodone,
  input wire logic [2:0]  resolved_speed_duplex,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        phy_irq,
  input wire logic        line_energy_present
);
  logic [7:0]  mask_q;
  logic [31:0] quiet_q;
  // Shadow of the mask and a count of cycles with no line energy.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mask_q  <= 8'h00;
      quiet_q <= 32'h0;
    end else begin
      if (wr && addr == 5'h1E) mask_q <= wdata[7:0];
      quiet_q <= ev.energy_seen ? 32'h0 : quiet_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Live fields are only compared when they held still over the read.
  flag_rsvd_a: assert property (
    rd && addr == 5'h1D |=> rdata[15:8] == 8'h00 && !rdata[0])
    else $error("Reserved flag bits read as one.");
  mask_read_a: assert property (
    rd && addr == 5'h1E |=> rdata == {8'h00, mask_q})
    else $error("Mask read-back differs.");
  status_live_a: assert property (
    rd && addr == 5'h1F && $stable({autodone, resolved_speed_duplex})
    |=> {rdata[15:12], rdata[4:0]} ==
        {3'h0, $past(autodone), $past(resolved_speed_duplex), 2'h0})
    else $error("Status live fields differ.");
  status_fill_a: assert property (
    rd && addr == 5'h1F |=> rdata[11:5] == 7'h02)
    else $error("Status filler field differs.");
  irq_masked_a: assert property (phy_irq |-> mask_q != 8'h00)
    else $error("Interrupt with every source masked.");
  energy_quiet_a: assert property (
    quiet_q > ENERGY_TIMEOUT_CYCLES + 2 |-> !line_energy_present)
    else $error("Energy still present after quiet timeout.");
  unmapped_a: assert property (
    rd && (addr < 5'h1A || addr == 5'h1C) |=> rdata == 16'h0)
    else $error("Unmapped read not zero.");
  rdata_idle_a: assert property (!rd |=> rdata == 16'h0)
    else $error("Read data outside a read cycle.");
endmodule
`default_nettype wire

// ---- tb/phy_event_flags_tb.sv ----
// Self-checking bench for the PHY event and status registers.
// Assumes the package, header, design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module phy_event_flags_tb;
  import phy_event_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        phy_irq;
  logic        blk_irq;
  logic        lep;
  phy_events_t ev;
  logic        autodone;
  logic [2:0]  spd;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          eb[6] = '{6, 4, 5, 2, 1, 3};
  int          fb[6] = '{1, 3, 2, 5, 6, 4};
  logic [2:0]  codes[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  always #25 clk_sys = ~clk_sys;
  phy_core_model PM (.clk_sys, .ev, .autodone, .spd);
  phy_event_flags #(.ENERGY_TIMEOUT_CYCLES(20)) DUT (.clk_sys, .rst_n,
    .ev, .autodone, .resolved_speed_duplex(spd), .addr, .wdata, .wr,
    .rd, .rdata, .phy_irq, .blk_irq, .line_energy_present(lep));
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bus tasks start just after an edge and leave an idle cycle behind.
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
    @(posedge clk_sys);
  endtask
  task automatic irq_chk(input bit b, input logic e);
    #1;
    if (b) `CHK("blk_irq", e, blk_irq)
    else `CHK("phy_irq", e, phy_irq)
    @(posedge clk_sys);
  endtask
  // A hang is cut short well beyond the fewer than two hundred cycles needed.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    PM.ev.link_up <= 1'b1;
    @(posedge clk_sys);
    rd_chk(5'h1D, 16'h0010);
    rd_chk(5'h1D, 16'h0000);
    rd_chk(5'h1E, 16'h0000);
    rd_chk(5'h1F, 16'h0044);
    rd_chk(5'h03, 16'h0000);
    wr_reg(5'h1D, 16'hFFFF);
    rd_chk(5'h1D, 16'h0000);
    wr_reg(5'h1E, 16'h00FF);
    rd_chk(5'h1E, 16'h00FF);
    // Each source but line energy is first masked alone, then enabled alone.
    for (int k = 0; k < 6; k++) begin
      wr_reg(5'h1E, 16'h00FF ^ (16'h1 << fb[k]));
      PM.blip(eb[k]);
      repeat (2) @(posedge clk_sys);
      irq_chk(0, 1'b0);
      wr_reg(5'h1E, 16'h1 << fb[k]);
      irq_chk(0, 1'b1);
      rd_chk(5'h1D, 16'h1 << fb[k]);
      irq_chk(0, 1'b0);
    end
    PM.ev.energy_seen <= 1'b0;
    repeat (30) @(posedge clk_sys);
    #1 `CHK("line_energy_present", 1'b0, lep)
    @(posedge clk_sys);
    PM.ev.energy_seen <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd_chk(5'h1D, 16'h0080);
    wr_reg(5'h1F, 16'h0040);
    PM.autodone <= 1'b1;
    foreach (codes[i]) begin
      PM.spd <= codes[i];
      @(posedge clk_sys);
      rd_chk(5'h1F, {3'h0, 1'b1, 7'h02, codes[i], 2'h0});
    end
    irq_chk(1, 1'b0);
    wr_reg(5'h1B, 16'h0003);
    irq_chk(1, 1'b1);
    rd_chk(5'h1A, 16'h0003);
    wr_reg(5'h1A, 16'h0003);
    rd_chk(5'h1A, 16'h0000);
    irq_chk(1, 1'b0);
    complete_run();
  end
endmodule
bind phy_event_flags phy_event_flags_checker #(
  .ENERGY_TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES)) chk (.*);
`default_nettype wire
